//--- tb/ack_partner.sv
// far-side model that consumes one pending record per acknowledge pulse
`timescale 1ns/1ps
module ack_partner (
  // clock
  input  wire logic       core_clk,
  // record handshake
  input  wire logic       valid,
  input  wire logic [3:0] delay,
  output logic            ack
);
  // wait the set number of cycles, pulse ack for one cycle, then look again
  initial begin
    ack = 1'b0;
  end
  always begin
    @(posedge core_clk);
    #2;
    if (valid === 1'b1) begin
      repeat (delay) begin
        @(posedge core_clk);
        #2;
      end
      ack = 1'b1;
      @(posedge core_clk);
      #2;
      ack = 1'b0;
    end
  end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the diagnostic and interrupt block
`timescale 1ns/1ps
module tb_top;
  import diag_pkg::*;
  logic core_clk, reset_n, comm_error, aux_supply_missing, diag_enable, od_path_sel;
  logic pi_valid, pi_emergency, pi_ack, diag_valid, diag_going, diag_channel, diag_ack;
  logic module_fault_indicator, rd_req, rd_od_path, rd_valid, rd_err;
  logic [7:0]  upper_limit_violation_flags, lower_limit_violation_flags, record_number, rd_data;
  logic [15:0] interrupt_timestamp_low, object_index;
  logic [31:0] diag_event_stamp;
  logic [4:0]  rd_byte;
  logic [1:0]  limit_enable;
  logic [3:0]  pi_dly, dg_dly;
  chan_in_t [NUM_CH-1:0] chan_in;
  logic [8:0]  rq[$];
  logic [16:0] pq[$];
  logic [2:0]  dq[$];
  int errors, checks_done, up, now_us, tb_edges;

  analog_input_diag_interrupt u_analog_input_diag_interrupt (
    .core_clk                    (core_clk),
    .reset_n                     (reset_n),
    .chan_in                     (chan_in),
    .comm_error                  (comm_error),
    .aux_supply_missing          (aux_supply_missing),
    .diag_enable                 (diag_enable),
    .limit_enable                (limit_enable),
    .od_path_sel                 (od_path_sel),
    .pi_valid                    (pi_valid),
    .upper_limit_violation_flags (upper_limit_violation_flags),
    .lower_limit_violation_flags (lower_limit_violation_flags),
    .interrupt_timestamp_low     (interrupt_timestamp_low),
    .pi_emergency                (pi_emergency),
    .pi_ack                      (pi_ack),
    .diag_valid                  (diag_valid),
    .diag_going                  (diag_going),
    .diag_channel                (diag_channel),
    .diag_event_stamp            (diag_event_stamp),
    .diag_ack                    (diag_ack),
    .module_fault_indicator      (module_fault_indicator),
    .rd_req                      (rd_req),
    .rd_od_path                  (rd_od_path),
    .record_number               (record_number),
    .object_index                (object_index),
    .rd_byte                     (rd_byte),
    .rd_valid                    (rd_valid),
    .rd_data                     (rd_data),
    .rd_err                      (rd_err)
  );

  // edges since reset release, the bench's own microsecond reference
  always @(posedge core_clk) begin
    if (reset_n === 1'b1) tb_edges <= tb_edges + 1;
  end
  ack_partner u_pi_partner (.core_clk(core_clk), .valid(pi_valid), .delay(pi_dly), .ack(pi_ack));
  ack_partner u_dg_partner (.core_clk(core_clk), .valid(diag_valid), .delay(dg_dly),
                            .ack(diag_ack));

  // clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  // one read request per cycle, held high across back-to-back calls
  task automatic rd(input logic od, input logic [7:0] rn, input logic [15:0] ix,
                    input int b, input logic [8:0] exp);
    rq.push_back(exp);
    rd_od_path = od;
    record_number = rn;
    object_index = ix;
    rd_byte = 5'(b);
    rd_req = 1'b1;
    wait_n(1);
  endtask

  task automatic rd_end;
    rd_req = 1'b0;
    wait_n(3);
  endtask

  task automatic meas(input int ch, input logic signed [15:0] v);
    chan_in[ch].value = v;
    chan_in[ch].meas_valid = 1'b1;
    wait_n(1);
    chan_in[ch].meas_valid = 1'b0;
    wait_n(1);
  endtask

  // record contents after reset, error flag above data
  function automatic logic [8:0] rec_exp(input int b, input int len);
    if (b >= len) return 9'h100;
    case (b)
      1: return 9'h015;
      4: return 9'h071;
      5: return 9'h008;
      6: return 9'h002;
      default: return 9'h000;
    endcase
  endfunction

  // result watcher, oldest note against each result
  always @(negedge core_clk) begin
    now_us = tb_edges / TICK_CYCLES;
    if (rd_valid === 1'b1)
      check({rd_err, rd_data}, rq.size() ? rq.pop_front() : 'x);
    if (pi_valid === 1'b1 && pi_ack === 1'b1) begin
      check({pi_emergency, upper_limit_violation_flags, lower_limit_violation_flags},
            pq.size() ? pq.pop_front() : 'x);
      check(now_us - interrupt_timestamp_low <= 1, 1);
    end
    if (diag_valid === 1'b1 && diag_ack === 1'b1) begin
      check({diag_going, diag_channel, module_fault_indicator},
            dq.size() ? dq.pop_front() : 'x);
      check(now_us - diag_event_stamp <= 1, 1);
    end
  end

  // hang guard
  initial begin
    #(30000 * 25);
    errors++;
    wrap_up();
  end

  initial begin
    {reset_n, comm_error, aux_supply_missing, diag_enable, od_path_sel, rd_req} = '0;
    {rd_od_path, record_number, object_index, rd_byte, limit_enable} = '0;
    {errors, checks_done} = '0;
    chan_in = '0;
    pi_dly = 4'h5;
    dg_dly = 4'h0;
    void'($urandom(18));
    wait_n(2);
    reset_n = 1'b1;
    // full and short record, both paths, refused selectors
    for (int b = 0; b <= 20; b++) rd(1'b0, 8'h01, 16'h0000, b, rec_exp(b, 20));
    for (int b = 0; b <= 4; b++) rd(1'b1, 8'h00, 16'h2f00, b, rec_exp(b, 4));
    rd(1'b0, 8'h00, 16'h0000, 4, 9'h100);
    rd(1'b0, 8'h02, 16'h0000, 0, 9'h100);
    rd(1'b1, 8'h01, 16'h2f02, 0, 9'h100);
    rd(1'b1, 8'h00, 16'h2f01, 19, 9'h000);
    rd_end();
    $display("test record reads done");
    wait_n(50);
    // limit crossings on each channel and direction, slow partner
    limit_enable = 2'b11;
    for (int c = 0; c < 4; c++) begin
      up = $urandom % 1000 + 1;
      od_path_sel = c[0];
      chan_in[c[0]].upper_limit = 16'(up);
      chan_in[c[0]].lower_limit = -16'(up);
      pq.push_back({c[0], c[1] ? 8'h00 : 8'(1 << c[0]), c[1] ? 8'(1 << c[0]) : 8'h00});
      meas(c[0], c[1] ? -16'(up + 1 + $urandom % 50) : 16'(up + 1 + $urandom % 50));
      wait_n(30);
      meas(c[0], 16'h0000);
      wait_n(20);
    end
    limit_enable = 2'b00;
    meas(0, 16'h7000);
    meas(0, 16'h0000);
    wait_n(20);
    // second crossing while a slow partner holds the first is lost
    pi_dly = 4'hf;
    limit_enable = 2'b01;
    od_path_sel = 1'b0;
    pq.push_back({1'b0, 8'h01, 8'h00});
    meas(0, 16'h7000);
    meas(0, 16'h0000);
    meas(0, 16'h7000);
    rd(1'b0, 8'h00, 16'h0000, 3, 9'h040);
    rd_end();
    wait_n(20);
    rd(1'b0, 8'h00, 16'h0000, 3, 9'h000);
    rd_end();
    meas(0, 16'h0000);
    limit_enable = 2'b00;
    wait_n(4);
    $display("test process interrupts done");
    // internal and supply flags, then one channel cause with an ignored extra cause
    diag_enable = 1'b1;
    {comm_error, aux_supply_missing} = 2'b11;
    wait_n(4);
    rd(1'b0, 8'h01, 16'h0000, 0, 9'h012);
    rd(1'b0, 8'h01, 16'h0000, 3, 9'h010);
    rd_end();
    {comm_error, aux_supply_missing} = 2'b00;
    wait_n(4);
    dq.push_back(3'b011);
    chan_in[1].param_err = 1'b1;
    wait_n(6);
    rd(1'b0, 8'h01, 16'h0000, 0, 9'h089);
    rd(1'b0, 8'h01, 16'h0000, 7, 9'h002);
    rd(1'b0, 8'h01, 16'h0000, 9, 9'h001);
    rd(1'b0, 8'h01, 16'h0000, 8, 9'h000);
    rd_end();
    chan_in[1].above_range = 1'b1;
    wait_n(4);
    rd(1'b0, 8'h01, 16'h0000, 9, 9'h001);
    rd_end();
    dq.push_back(3'b110);
    chan_in[1].param_err = 1'b0;
    chan_in[1].above_range = 1'b0;
    wait_n(6);
    rd(1'b0, 8'h01, 16'h0000, 9, 9'h000);
    rd(1'b0, 8'h01, 16'h0000, 0, 9'h000);
    rd(1'b0, 8'h01, 16'h0000, 7, 9'h000);
    rd_end();
    // cause clears while the incoming event waits: overflow flagged, going follows ack
    dg_dly = 4'hf;
    dq.push_back(3'b001);
    dq.push_back(3'b100);
    chan_in[0].supply_fault = 1'b1;
    wait_n(2);
    chan_in[0].supply_fault = 1'b0;
    wait_n(2);
    rd(1'b0, 8'h01, 16'h0000, 3, 9'h008);
    rd(1'b0, 8'h01, 16'h0000, 0, 9'h00f);
    rd_end();
    wait_n(40);
    rd(1'b0, 8'h01, 16'h0000, 3, 9'h000);
    rd_end();
    $display("test diagnostic events done");
    check(32'(rq.size() + pq.size() + dq.size()), 0);
    wrap_up();
  end
endmodule

//--- verilog/analog_input_diag_interrupt.sv
// process and diagnostic interrupt reporting for a two-channel analog input module
`timescale 1ns/1ps
module analog_input_diag_interrupt
  import diag_pkg::*;
(
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      reset_n,
  // measurement side
  input  wire chan_in_t [NUM_CH-1:0]     chan_in,
  input  wire logic                      comm_error,
  input  wire logic                      aux_supply_missing,
  // configuration
  input  wire logic                      diag_enable,
  input  wire logic [NUM_CH-1:0]         limit_enable,
  input  wire logic                      od_path_sel,
  // process interrupt record
  output logic                           pi_valid,
  output logic [7:0]                     upper_limit_violation_flags,
  output logic [7:0]                     lower_limit_violation_flags,
  output logic [15:0]                    interrupt_timestamp_low,
  output logic                           pi_emergency,
  input  wire logic                      pi_ack,
  // diagnostic events
  output logic                           diag_valid,
  output logic                           diag_going,
  output logic                           diag_channel,
  output logic [31:0]                    diag_event_stamp,
  input  wire logic                      diag_ack,
  output logic                           module_fault_indicator,
  // record read port
  input  wire logic                      rd_req,
  input  wire logic                      rd_od_path,
  input  wire logic [7:0]                record_number,
  input  wire logic [15:0]               object_index,
  input  wire logic [4:0]                rd_byte,
  output logic                           rd_valid,
  output logic [7:0]                     rd_data,
  output logic                           rd_err
);

  state_t q;
  state_t d;

  // cause byte of one channel from live inputs and the lost flag
  function automatic logic [7:0] cause_byte(chan_in_t c, logic lost);
    logic [7:0] b;
    b = 8'h00;
    b[CE_PARAM]  = c.param_err;
    b[CE_ABOVE]  = c.above_range;
    b[CE_BELOW]  = c.below_range;
    b[CE_SUPPLY] = c.supply_fault;
    b[CE_LOST]   = lost;
    b[CE_UNDER]  = c.range_under;
    b[CE_OVER]   = c.range_over;
    return b;
  endfunction

  // one byte of the diagnostic record
  function automatic logic [7:0] rec_byte(state_t s, logic [4:0] ofs, logic comm);
    logic [7:0] b;
    b = 8'h00;
    unique case (ofs)
      OFS_SUMMARY: begin
        b[SUM_FAIL]  = |s.active;
        b[SUM_INT]   = s.buf_ovf | comm;
        b[SUM_EXT]   = s.ch_err[0][CE_SUPPLY] | s.ch_err[1][CE_SUPPLY];
        b[SUM_CHAN]  = |s.active;
        b[SUM_AUX]   = s.aux_s2;
        b[SUM_PARAM] = s.ch_err[0][CE_PARAM] | s.ch_err[1][CE_PARAM];
      end
      OFS_MODCLASS: b = MODCLASS_VAL;
      OFS_DETAIL: begin
        b[DET_BUFOVF] = s.buf_ovf;
        b[DET_COMM]   = comm;
        b[DET_LOST]   = |s.lost_pi;
      end
      OFS_CHKIND:   b = CHKIND_VAL;
      OFS_BITSPC:   b = BITSPC_VAL;
      OFS_CHCOUNT:  b = CHCOUNT_VAL;
      OFS_CHGROUP:  b = {6'h00, s.active};
      OFS_CH0:      b = s.ch_err[0];
      OFS_CH1:      b = s.ch_err[1];
      5'h10, 5'h11, 5'h12, 5'h13: b = s.diag_ts[8*(ofs-OFS_STAMP) +: 8];
      default:      b = 8'h00;
    endcase
    return b;
  endfunction

  // next-state logic
  always_comb begin
    logic [NUM_CH-1:0] up_rise;
    logic [NUM_CH-1:0] lo_rise;
    logic [NUM_CH-1:0][7:0] cause;
    logic [NUM_CH-1:0] need;
    logic              full_sel;
    logic              short_sel;
    logic              done;
    d = q;
    up_rise = '0;
    lo_rise = '0;
    cause = '0;
    need = '0;
    full_sel = 1'b0;
    short_sel = 1'b0;
    done = 1'b0;

    // aux supply pin synchroniser
    d.aux_s1 = aux_supply_missing;
    d.aux_s2 = q.aux_s1;

    // microsecond ticker, wraps by overflow
    if (q.presc == PRESC_W'(TICK_CYCLES - 1)) begin
      d.presc  = '0;
      d.ticker = q.ticker + 32'h0000_0001;
    end else begin
      d.presc = q.presc + PRESC_W'(1);
    end

    // limit comparison on each new sample
    for (int c = 0; c < NUM_CH; c++) begin
      if (chan_in[c].meas_valid) begin
        d.up_prev[c] = chan_in[c].value > chan_in[c].upper_limit;
        d.lo_prev[c] = chan_in[c].value < chan_in[c].lower_limit;
        up_rise[c] = d.up_prev[c] & ~q.up_prev[c] & limit_enable[c];
        lo_rise[c] = d.lo_prev[c] & ~q.lo_prev[c] & limit_enable[c];
      end
    end

    // process interrupt delivery; a new event wins over the ack
    if (pi_ack) begin
      d.pi_valid = 1'b0;
      d.lost_pi  = '0;
    end
    if (|(up_rise | lo_rise)) begin
      if (q.pi_valid && !pi_ack) begin
        d.lost_pi = q.lost_pi | up_rise | lo_rise;
      end else begin
        d.pi_valid = 1'b1;
        d.pi_upper = {6'h00, up_rise};
        d.pi_lower = {6'h00, lo_rise};
        d.pi_ts    = q.ticker[15:0];
        d.pi_emerg = od_path_sel;
      end
    end

    // diagnostic incoming and going events, one per cycle
    if (diag_ack) begin
      d.diag_valid = 1'b0;
      d.buf_ovf    = 1'b0;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      cause[c] = cause_byte(chan_in[c], q.lost_pi[c]);
      need[c]  = (!q.active[c] && cause[c] != 8'h00) || (q.active[c] && cause[c] == 8'h00);
    end
    if (!diag_enable) begin
      d.active = '0;
      d.ch_err = '0;
    end else if (|need) begin
      if (q.diag_valid && !diag_ack) begin
        d.buf_ovf = 1'b1;
      end else begin
        for (int c = 0; c < NUM_CH; c++) begin
          if (need[c] && !done) begin
            done         = 1'b1;
            d.diag_valid = 1'b1;
            d.diag_ch    = 1'(c);
            d.diag_ts    = q.ticker;
            d.diag_going = q.active[c];
            d.active[c]  = !q.active[c];
            d.ch_err[c]  = q.active[c] ? 8'h00 : cause[c];
          end
        end
      end
    end
    // a live channel keeps its captured byte, later causes ignored until all clear

    d.fault_led = |d.active;

    // record reads, answered one cycle later
    full_sel  = rd_od_path ? (object_index == IDX_FULL) : (record_number == REC_FULL);
    short_sel = rd_od_path ? (object_index == IDX_SHORT) : (record_number == REC_SHORT);
    d.rd_valid = rd_req;
    d.rd_data  = 8'h00;
    d.rd_err   = 1'b0;
    if (rd_req) begin
      if ((full_sel && rd_byte < 5'(LEN_FULL)) ||
          (short_sel && rd_byte < 5'(LEN_SHORT))) begin
        d.rd_data = rec_byte(q, rd_byte, comm_error);
      end else begin
        d.rd_err = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state
  assign pi_valid                    = q.pi_valid;
  assign upper_limit_violation_flags = q.pi_upper;
  assign lower_limit_violation_flags = q.pi_lower;
  assign interrupt_timestamp_low     = q.pi_ts;
  assign pi_emergency                = q.pi_emerg;
  assign diag_valid                  = q.diag_valid;
  assign diag_going                  = q.diag_going;
  assign diag_channel                = q.diag_ch;
  assign diag_event_stamp            = q.diag_ts;
  assign module_fault_indicator      = q.fault_led;
  assign rd_valid                    = q.rd_valid;
  assign rd_data                     = q.rd_data;
  assign rd_err                      = q.rd_err;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  ticker_step_a: assert property (
    $past(q.presc) == PRESC_W'(TICK_CYCLES - 1) |-> q.ticker == $past(q.ticker) + 32'h1)
    else $error("ticker did not advance at prescaler end");

  ticker_hold_a: assert property (
    $past(q.presc) != PRESC_W'(TICK_CYCLES - 1) |-> $stable(q.ticker))
    else $error("ticker moved mid-microsecond");

  pi_stamp_a: assert property (
    $rose(q.pi_valid) |-> q.pi_ts == $past(q.ticker[15:0]))
    else $error("interrupt stamp not ticker low half");

  pi_gate_a: assert property (
    $rose(q.pi_valid) |-> ((q.pi_upper[1:0] | q.pi_lower[1:0]) & ~$past(limit_enable)) == 2'b00)
    else $error("interrupt raised on disabled channel");

  pi_rsvd_a: assert property (
    q.pi_upper[7:2] == 6'h00 && q.pi_lower[7:2] == 6'h00)
    else $error("reserved interrupt bits set");

  led_span_a: assert property (
    $rose(q.diag_valid) && !q.diag_going |-> q.fault_led)
    else $error("fault indicator off at incoming event");

  going_clear_a: assert property (
    $rose(q.diag_valid) && q.diag_going |-> q.ch_err[q.diag_ch] == 8'h00)
    else $error("flags left set at going event");

  hold_byte_a: assert property (
    q.active[0] && $past(q.active[0]) && diag_enable ##1 q.active[0] |-> $stable(q.ch_err[0]))
    else $error("channel byte changed while active");

  diag_stamp_a: assert property (
    $rose(q.diag_valid) |-> q.diag_ts == $past(q.ticker))
    else $error("diagnostic stamp not full ticker");

  short_len_a: assert property (
    rd_req && !rd_od_path && record_number == REC_SHORT && rd_byte >= 5'(LEN_SHORT)
      |=> rd_valid && rd_err)
    else $error("short record read past four bytes");

  modclass_a: assert property (
    rd_req && rd_od_path && object_index == IDX_FULL && rd_byte == OFS_MODCLASS
      |=> rd_data == MODCLASS_VAL && !rd_err)
    else $error("module class byte wrong");

endmodule

//--- verilog/diag_pkg.sv
// constants, field layouts and carrier types for the analog input diagnostic block
package diag_pkg;

  localparam int NUM_CH = 2;

  // timing
  localparam int TICK_NS       = 1000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int PRESC_W       = 6;

  // record selectors
  localparam logic [7:0]  REC_SHORT = 8'h00;
  localparam logic [7:0]  REC_FULL  = 8'h01;
  localparam logic [15:0] IDX_SHORT = 16'h2f00;
  localparam logic [15:0] IDX_FULL  = 16'h2f01;
  localparam int          LEN_SHORT = 4;
  localparam int          LEN_FULL  = 20;

  // record byte offsets
  localparam logic [4:0] OFS_SUMMARY  = 5'h00;
  localparam logic [4:0] OFS_MODCLASS = 5'h01;
  localparam logic [4:0] OFS_RSVD     = 5'h02;
  localparam logic [4:0] OFS_DETAIL   = 5'h03;
  localparam logic [4:0] OFS_CHKIND   = 5'h04;
  localparam logic [4:0] OFS_BITSPC   = 5'h05;
  localparam logic [4:0] OFS_CHCOUNT  = 5'h06;
  localparam logic [4:0] OFS_CHGROUP  = 5'h07;
  localparam logic [4:0] OFS_CH0      = 5'h08;
  localparam logic [4:0] OFS_CH1      = 5'h09;
  localparam logic [4:0] OFS_STAMP    = 5'h10;

  // fixed record contents
  localparam logic [7:0] MODCLASS_VAL = 8'h15;
  localparam logic [7:0] CHKIND_VAL   = 8'h71;
  localparam logic [7:0] BITSPC_VAL   = 8'h08;
  localparam logic [7:0] CHCOUNT_VAL  = 8'h02;

  // summary byte bits
  localparam int SUM_FAIL  = 0;
  localparam int SUM_INT   = 1;
  localparam int SUM_EXT   = 2;
  localparam int SUM_CHAN  = 3;
  localparam int SUM_AUX   = 4;
  localparam int SUM_PARAM = 7;
  // detail byte bits
  localparam int DET_BUFOVF = 3;
  localparam int DET_COMM   = 4;
  localparam int DET_LOST   = 6;
  // per-channel byte bits
  localparam int CE_PARAM  = 0;
  localparam int CE_ABOVE  = 1;
  localparam int CE_BELOW  = 2;
  localparam int CE_SUPPLY = 4;
  localparam int CE_LOST   = 5;
  localparam int CE_UNDER  = 6;
  localparam int CE_OVER   = 7;

  // measurement-side signals of one channel
  typedef struct packed {
    logic               param_err;
    logic               above_range;
    logic               below_range;
    logic               range_under;
    logic               range_over;
    logic               supply_fault;
    logic               meas_valid;
    logic signed [15:0] value;
    logic signed [15:0] upper_limit;
    logic signed [15:0] lower_limit;
  } chan_in_t;

  // whole block state
  typedef struct packed {
    logic [31:0]             ticker;
    logic [PRESC_W-1:0]      presc;
    logic [NUM_CH-1:0]       active;
    logic [NUM_CH-1:0][7:0]  ch_err;
    logic [NUM_CH-1:0]       lost_pi;
    logic [NUM_CH-1:0]       up_prev;
    logic [NUM_CH-1:0]       lo_prev;
    logic                    pi_valid;
    logic [7:0]              pi_upper;
    logic [7:0]              pi_lower;
    logic [15:0]             pi_ts;
    logic                    pi_emerg;
    logic                    diag_valid;
    logic                    diag_going;
    logic                    diag_ch;
    logic [31:0]             diag_ts;
    logic                    buf_ovf;
    logic                    rd_valid;
    logic [7:0]              rd_data;
    logic                    rd_err;
    logic                    fault_led;
    logic                    aux_s1;
    logic                    aux_s2;
  } state_t;

endpackage
